// ---- src/pemux_pkg.sv ----
// Package with register map, field positions and reset values of the port E pin mux
package pemux_pkg;
  // Word byte addresses
  localparam logic [7:0] ADDR_PE_SEL_LOW = 8'h00;
  localparam logic [7:0] ADDR_PE_SEL_HIGH = 8'h04;
  localparam logic [7:0] ADDR_TMR_ROUTE = 8'h08;
  localparam logic [7:0] ADDR_SER_ROUTE = 8'h0c;
  localparam logic [7:0] ADDR_PA_DATA = 8'h10;
  localparam logic [7:0] ADDR_PA_DIR = 8'h14;
  localparam logic [7:0] ADDR_PE_DATA = 8'h18;
  localparam logic [7:0] ADDR_PE_DIR = 8'h1c;
  localparam logic [7:0] ADDR_PA_WAKE_EN = 8'h20;
  localparam logic [7:0] ADDR_PA_PINS = 8'h24;
  localparam logic [7:0] ADDR_PE_PINS = 8'h28;
  // Implemented bits masks
  localparam logic [7:0] MASK_PE_SEL_HIGH = 8'h03;
  localparam logic [7:0] MASK_TMR_ROUTE = 8'hc9;
  localparam logic [7:0] MASK_SER_ROUTE = 8'h71;
  localparam logic [4:0] MASK_PE_PORT = 5'h1f;
  // Field positions
  localparam int POS_PIN3_FUNC = 6;
  localparam int POS_PIN2_FUNC = 4;
  localparam int POS_PIN1_FUNC = 2;
  localparam int POS_PIN0_FUNC = 0;
  localparam int POS_PIN4_FUNC = 0;
  localparam int POS_PT2_CAP = 7;
  localparam int POS_PT1_CAP = 6;
  localparam int POS_PT2_CLK = 3;
  localparam int POS_STD_CLK = 0;
  localparam int POS_SPI_SEL = 6;
  localparam int POS_SPI_DIN = 5;
  localparam int POS_SPI_CLK = 4;
  localparam int POS_SHARED_RX = 0;
  // Function codes
  localparam logic [1:0] FUNC_ANALOG = 2'h1;
  localparam logic [1:0] FUNC_OPAMP = 2'h2;
  localparam logic [1:0] FUNC_SUPPLY = 2'h1;
  // Reset values
  localparam logic [7:0] RST_SEL = 8'h00;
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [7:0] RST_WAKE = 8'h00;
endpackage : pemux_pkg

// ---- src/pemux_top.sv ----
// Port E function mux, input source routing, port A/E registers and port A wake-up
`timescale 1ns/10ps
module pemux_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Package pins, asynchronous
  input wire logic [7:0] pa_pin_i,
  input wire logic [7:0] pb_pin_i,
  input wire logic [7:0] pc_pin_i,
  input wire logic [4:0] pe_pin_i,
  // Port A and E pin drivers, enable active low
  output logic [7:0] pa_out_o,
  output logic [7:0] pa_oe_n_o,
  output logic [4:0] pe_out_o,
  output logic [4:0] pe_oe_n_o,
  // Port E analog switches
  output logic analog_channel_7_o,
  output logic analog_channel_6_o,
  output logic analog_channel_5_o,
  output logic analog_channel_4_o,
  output logic opamp_noninv_input_o,
  output logic opamp_inv_input_o,
  output logic io_supply_ref_o,
  // Routed peripheral inputs
  output logic ptimer2_capture_in_o,
  output logic ptimer1_capture_in_o,
  output logic ptimer2_ext_clock_o,
  output logic std_timer_ext_clock_o,
  output logic spi_a_select_o,
  output logic spi_a_data_in_o,
  output logic spi_a_clock_o,
  output logic shared_serial_rx_in_o,
  // Power state and wake
  input wire logic sleep_i,
  output logic wake_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [28:0] sync1_reg, sync1_next;
  logic [28:0] sync2_reg, sync2_next;
  logic [7:0] pa_prev_reg, pa_prev_next;
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [7:0] pc_s;
  logic [4:0] pe_s;

  // Only the second stage feeds logic; the first may be metastable
  always_comb begin
    sync1_next = {pe_pin_i, pc_pin_i, pb_pin_i, pa_pin_i};
    sync2_next = sync1_reg;
    pa_prev_next = pa_s;
  end

  always_ff @(posedge clk_i) begin
    sync1_reg <= sync1_next;
    sync2_reg <= sync2_next;
    pa_prev_reg <= pa_prev_next;
  end

  assign pa_s = sync2_reg[7:0];
  assign pb_s = sync2_reg[15:8];
  assign pc_s = sync2_reg[23:16];
  assign pe_s = sync2_reg[28:24];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] pe_sel_low_reg, pe_sel_low_next;
  logic [7:0] pe_sel_high_reg, pe_sel_high_next;
  logic [7:0] tmr_route_reg, tmr_route_next;
  logic [7:0] ser_route_reg, ser_route_next;
  logic [7:0] pa_data_reg, pa_data_next;
  logic [7:0] pa_dir_reg, pa_dir_next;
  logic [4:0] pe_data_reg, pe_data_next;
  logic [4:0] pe_dir_reg, pe_dir_next;
  logic [7:0] wake_en_reg, wake_en_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_en;
  logic rd_en;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] dat,
                                            input logic [3:0] sel, input logic [7:0] mask);
    merge_byte = sel[0] ? (dat[7:0] & mask) : old_v;
  endfunction : merge_byte

  // Data reads return the pin level for inputs and the latch for outputs
  function automatic logic [7:0] port_read(input logic [7:0] data_v, input logic [7:0] dir_v,
                                           input logic [7:0] pin_v);
    port_read = (data_v & ~dir_v) | (pin_v & dir_v);
  endfunction : port_read

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_reg;

  always_comb begin
    pe_sel_low_next = pe_sel_low_reg;
    pe_sel_high_next = pe_sel_high_reg;
    tmr_route_next = tmr_route_reg;
    ser_route_next = ser_route_reg;
    pa_data_next = pa_data_reg;
    pa_dir_next = pa_dir_reg;
    pe_data_next = pe_data_reg;
    pe_dir_next = pe_dir_reg;
    wake_en_next = wake_en_reg;
    if (wr_en) begin
      unique case (wb_adr_i)
        pemux_pkg::ADDR_PE_SEL_LOW: pe_sel_low_next = merge_byte(pe_sel_low_reg, wb_dat_i,
                                                    wb_sel_i, 8'hff);
        pemux_pkg::ADDR_PE_SEL_HIGH: pe_sel_high_next = merge_byte(pe_sel_high_reg, wb_dat_i,
                                                    wb_sel_i, pemux_pkg::MASK_PE_SEL_HIGH);
        pemux_pkg::ADDR_TMR_ROUTE: tmr_route_next = merge_byte(tmr_route_reg, wb_dat_i,
                                                    wb_sel_i, pemux_pkg::MASK_TMR_ROUTE);
        pemux_pkg::ADDR_SER_ROUTE: ser_route_next = merge_byte(ser_route_reg, wb_dat_i,
                                                    wb_sel_i, pemux_pkg::MASK_SER_ROUTE);
        // Whole-byte writes only; bit ops are read-modify-write by software
        pemux_pkg::ADDR_PA_DATA: pa_data_next = merge_byte(pa_data_reg, wb_dat_i,
                                                    wb_sel_i, 8'hff);
        pemux_pkg::ADDR_PA_DIR: pa_dir_next = merge_byte(pa_dir_reg, wb_dat_i, wb_sel_i, 8'hff);
        pemux_pkg::ADDR_PE_DATA: pe_data_next = wb_sel_i[0] ? wb_dat_i[4:0] : pe_data_reg;
        pemux_pkg::ADDR_PE_DIR: pe_dir_next = wb_sel_i[0] ? wb_dat_i[4:0] : pe_dir_reg;
        pemux_pkg::ADDR_PA_WAKE_EN: wake_en_next = merge_byte(wake_en_reg, wb_dat_i,
                                                    wb_sel_i, 8'hff);
        default: ;
      endcase
    end
  end

  // Bus answer: ack one cycle after the taking edge, read data with it
  always_comb begin
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    rdata_next = 32'h0000_0000;
    if (rd_en) begin
      unique case (wb_adr_i)
        pemux_pkg::ADDR_PE_SEL_LOW: rdata_next[7:0] = pe_sel_low_reg;
        pemux_pkg::ADDR_PE_SEL_HIGH: rdata_next[7:0] = pe_sel_high_reg &
                                                       pemux_pkg::MASK_PE_SEL_HIGH;
        pemux_pkg::ADDR_TMR_ROUTE: rdata_next[7:0] = tmr_route_reg;
        pemux_pkg::ADDR_SER_ROUTE: rdata_next[7:0] = ser_route_reg;
        // Data reads return pin levels where the pin is an input
        pemux_pkg::ADDR_PA_DATA: rdata_next[7:0] = port_read(pa_data_reg, pa_dir_reg,
                                                             pa_s);
        pemux_pkg::ADDR_PA_DIR: rdata_next[7:0] = pa_dir_reg;
        pemux_pkg::ADDR_PE_DATA: rdata_next[7:0] = port_read({3'h0, pe_data_reg},
                                                             {3'h0, pe_dir_reg}, {3'h0, pe_s});
        pemux_pkg::ADDR_PE_DIR: rdata_next[4:0] = pe_dir_reg;
        pemux_pkg::ADDR_PA_WAKE_EN: rdata_next[7:0] = wake_en_reg;
        pemux_pkg::ADDR_PA_PINS: rdata_next[7:0] = pa_s;
        pemux_pkg::ADDR_PE_PINS: rdata_next[4:0] = pe_s;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pe_sel_low_reg <= pemux_pkg::RST_SEL;
      pe_sel_high_reg <= pemux_pkg::RST_SEL;
      tmr_route_reg <= pemux_pkg::RST_SEL;
      ser_route_reg <= pemux_pkg::RST_SEL;
      pa_data_reg <= pemux_pkg::RST_PORT;
      pa_dir_reg <= pemux_pkg::RST_PORT;
      pe_data_reg <= pemux_pkg::MASK_PE_PORT;
      pe_dir_reg <= pemux_pkg::MASK_PE_PORT;
      wake_en_reg <= pemux_pkg::RST_WAKE;
    end else begin
      pe_sel_low_reg <= pe_sel_low_next;
      pe_sel_high_reg <= pe_sel_high_next;
      tmr_route_reg <= tmr_route_next;
      ser_route_reg <= ser_route_next;
      pa_data_reg <= pa_data_next;
      pa_dir_reg <= pa_dir_next;
      pe_data_reg <= pe_data_next;
      pe_dir_reg <= pe_dir_next;
      wake_en_reg <= wake_en_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Function decode, routing and pin drive
  logic [1:0] f3;
  logic [1:0] f2;
  logic [1:0] f1;
  logic [1:0] f0;
  logic [1:0] f4;
  logic [4:0] pe_gpio;
  logic analog_channel_7_reg, analog_channel_7_next;
  logic analog_channel_6_reg, analog_channel_6_next;
  logic analog_channel_5_reg, analog_channel_5_next;
  logic analog_channel_4_reg, analog_channel_4_next;
  logic opamp_noninv_input_reg, opamp_noninv_input_next;
  logic opamp_inv_input_reg, opamp_inv_input_next;
  logic io_supply_ref_reg, io_supply_ref_next;
  logic ptimer2_capture_in_reg, ptimer2_capture_in_next;
  logic ptimer1_capture_in_reg, ptimer1_capture_in_next;
  logic ptimer2_ext_clock_reg, ptimer2_ext_clock_next;
  logic std_timer_ext_clock_reg, std_timer_ext_clock_next;
  logic spi_a_select_reg, spi_a_select_next;
  logic spi_a_data_in_reg, spi_a_data_in_next;
  logic spi_a_clock_reg, spi_a_clock_next;
  logic shared_serial_rx_in_reg, shared_serial_rx_in_next;
  logic [7:0] pa_out_reg, pa_out_next;
  logic [7:0] pa_oe_n_reg, pa_oe_n_next;
  logic [4:0] pe_out_reg, pe_out_next;
  logic [4:0] pe_oe_n_reg, pe_oe_n_next;
  logic wake_reg, wake_next;

  // Two-bit function field starting at a bit position
  function automatic logic [1:0] func_field(input logic [7:0] sel_v, input int pos);
    func_field = sel_v[pos +: 2];
  endfunction : func_field

  // Routed input: alternate pin when the route bit is set
  function automatic logic route_pick(input logic route_bit, input logic alt_pin,
                                      input logic dflt_pin);
    route_pick = route_bit ? alt_pin : dflt_pin;
  endfunction : route_pick

  assign f3 = func_field(pe_sel_low_reg, pemux_pkg::POS_PIN3_FUNC);
  assign f2 = func_field(pe_sel_low_reg, pemux_pkg::POS_PIN2_FUNC);
  assign f1 = func_field(pe_sel_low_reg, pemux_pkg::POS_PIN1_FUNC);
  assign f0 = func_field(pe_sel_low_reg, pemux_pkg::POS_PIN0_FUNC);
  assign f4 = func_field(pe_sel_high_reg, pemux_pkg::POS_PIN4_FUNC);

  // Analog and op-amp switch selects
  always_comb begin
    analog_channel_7_next = (f3 == pemux_pkg::FUNC_ANALOG);
    analog_channel_6_next = (f2 == pemux_pkg::FUNC_ANALOG);
    analog_channel_5_next = (f1 == pemux_pkg::FUNC_ANALOG);
    analog_channel_4_next = (f0 == pemux_pkg::FUNC_ANALOG);
    opamp_noninv_input_next = (f1 == pemux_pkg::FUNC_OPAMP);
    opamp_inv_input_next = (f0 == pemux_pkg::FUNC_OPAMP);
    io_supply_ref_next = (f4 == pemux_pkg::FUNC_SUPPLY);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_channel_7_reg <= 1'b0;
      analog_channel_6_reg <= 1'b0;
      analog_channel_5_reg <= 1'b0;
      analog_channel_4_reg <= 1'b0;
      opamp_noninv_input_reg <= 1'b0;
      opamp_inv_input_reg <= 1'b0;
      io_supply_ref_reg <= 1'b0;
    end else begin
      analog_channel_7_reg <= analog_channel_7_next;
      analog_channel_6_reg <= analog_channel_6_next;
      analog_channel_5_reg <= analog_channel_5_next;
      analog_channel_4_reg <= analog_channel_4_next;
      opamp_noninv_input_reg <= opamp_noninv_input_next;
      opamp_inv_input_reg <= opamp_inv_input_next;
      io_supply_ref_reg <= io_supply_ref_next;
    end
  end

  // Peripheral input routing from the synchronised pins
  always_comb begin
    ptimer2_capture_in_next = route_pick(tmr_route_reg[pemux_pkg::POS_PT2_CAP], pc_s[2],
                                         pa_s[4]);
    ptimer1_capture_in_next = route_pick(tmr_route_reg[pemux_pkg::POS_PT1_CAP], pc_s[0],
                                         pa_s[3]);
    ptimer2_ext_clock_next = route_pick(tmr_route_reg[pemux_pkg::POS_PT2_CLK], pa_s[7],
                                        pc_s[3]);
    std_timer_ext_clock_next = route_pick(tmr_route_reg[pemux_pkg::POS_STD_CLK], pa_s[6],
                                          pa_s[1]);
    spi_a_select_next = route_pick(ser_route_reg[pemux_pkg::POS_SPI_SEL], pc_s[4],
                                   pa_s[4]);
    spi_a_data_in_next = route_pick(ser_route_reg[pemux_pkg::POS_SPI_DIN], pb_s[3],
                                    pa_s[6]);
    spi_a_clock_next = route_pick(ser_route_reg[pemux_pkg::POS_SPI_CLK], pb_s[2],
                                  pa_s[5]);
    shared_serial_rx_in_next = route_pick(ser_route_reg[pemux_pkg::POS_SHARED_RX], pc_s[5],
                                          pa_s[7]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptimer2_capture_in_reg <= 1'b0;
      ptimer1_capture_in_reg <= 1'b0;
      ptimer2_ext_clock_reg <= 1'b0;
      std_timer_ext_clock_reg <= 1'b0;
      spi_a_select_reg <= 1'b0;
      spi_a_data_in_reg <= 1'b0;
      spi_a_clock_reg <= 1'b0;
      shared_serial_rx_in_reg <= 1'b0;
    end else begin
      ptimer2_capture_in_reg <= ptimer2_capture_in_next;
      ptimer1_capture_in_reg <= ptimer1_capture_in_next;
      ptimer2_ext_clock_reg <= ptimer2_ext_clock_next;
      std_timer_ext_clock_reg <= std_timer_ext_clock_next;
      spi_a_select_reg <= spi_a_select_next;
      spi_a_data_in_reg <= spi_a_data_in_next;
      spi_a_clock_reg <= spi_a_clock_next;
      shared_serial_rx_in_reg <= shared_serial_rx_in_next;
    end
  end

  // Pin drivers: a pin given to a non-GPIO function is never driven
  always_comb begin
    pe_gpio[3] = !analog_channel_7_next;
    pe_gpio[2] = !analog_channel_6_next;
    pe_gpio[1] = !(analog_channel_5_next || opamp_noninv_input_next);
    pe_gpio[0] = !(analog_channel_4_next || opamp_inv_input_next);
    pe_gpio[4] = !io_supply_ref_next;
    // Output level is the data register, high after reset
    pa_out_next = pa_data_reg;
    pa_oe_n_next = pa_dir_reg;
    pe_out_next = pe_data_reg;
    pe_oe_n_next = pe_dir_reg | ~pe_gpio;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_out_reg <= pemux_pkg::RST_PORT;
      pa_oe_n_reg <= pemux_pkg::RST_PORT;
      pe_out_reg <= pemux_pkg::MASK_PE_PORT;
      pe_oe_n_reg <= pemux_pkg::MASK_PE_PORT;
    end else begin
      pa_out_reg <= pa_out_next;
      pa_oe_n_reg <= pa_oe_n_next;
      pe_out_reg <= pe_out_next;
      pe_oe_n_reg <= pe_oe_n_next;
    end
  end

  // Wake on a falling edge of an enabled port A pin while asleep
  always_comb begin
    wake_next = sleep_i && |(wake_en_reg & pa_prev_reg & ~pa_s);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= wake_next;
    end
  end

  assign analog_channel_7_o = analog_channel_7_reg;
  assign analog_channel_6_o = analog_channel_6_reg;
  assign analog_channel_5_o = analog_channel_5_reg;
  assign analog_channel_4_o = analog_channel_4_reg;
  assign opamp_noninv_input_o = opamp_noninv_input_reg;
  assign opamp_inv_input_o = opamp_inv_input_reg;
  assign io_supply_ref_o = io_supply_ref_reg;
  assign ptimer2_capture_in_o = ptimer2_capture_in_reg;
  assign ptimer1_capture_in_o = ptimer1_capture_in_reg;
  assign ptimer2_ext_clock_o = ptimer2_ext_clock_reg;
  assign std_timer_ext_clock_o = std_timer_ext_clock_reg;
  assign spi_a_select_o = spi_a_select_reg;
  assign spi_a_data_in_o = spi_a_data_in_reg;
  assign spi_a_clock_o = spi_a_clock_reg;
  assign shared_serial_rx_in_o = shared_serial_rx_in_reg;
  assign pa_out_o = pa_out_reg;
  assign pa_oe_n_o = pa_oe_n_reg;
  assign pe_out_o = pe_out_reg;
  assign pe_oe_n_o = pe_oe_n_reg;
  assign wake_o = wake_reg;

endmodule : pemux_top

// ---- testbench/pemux_sva.sv ----
// Checker for pin functions, reset state, routing and wake gating
`timescale 1ns/10ps
module pemux_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic wb_ack_o,
  input wire logic [7:0] pa_pin_i,
  input wire logic [7:0] pc_pin_i,
  input wire logic [7:0] pa_out_o,
  input wire logic [7:0] pa_oe_n_o,
  input wire logic [4:0] pe_oe_n_o,
  input wire logic analog_channel_7_o,
  input wire logic analog_channel_6_o,
  input wire logic analog_channel_5_o,
  input wire logic opamp_noninv_input_o,
  input wire logic io_supply_ref_o,
  input wire logic ptimer2_capture_in_o,
  input wire logic sleep_i,
  input wire logic wake_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_pe3_analog_float: assert property (analog_channel_7_o |-> pe_oe_n_o[3])
    else $error("pin 3 driven");
  a_pe2_analog_float: assert property (analog_channel_6_o |-> pe_oe_n_o[2])
    else $error("pin 2 driven");
  a_pe1_one_function: assert property (analog_channel_5_o |-> !opamp_noninv_input_o)
    else $error("pin 1 two functions");
  a_pe4_supply_float: assert property (io_supply_ref_o |-> pe_oe_n_o[4])
    else $error("pin 4 driven");
  a_reset_all_ones: assert property ($past(rst_i) |-> (pa_out_o & pa_oe_n_o) == 8'hff)
    else $error("port not ones");
  a_wake_only_asleep: assert property (!sleep_i |=> !wake_o)
    else $error("wake while awake");
  a_cap_route_level: assert property ((pa_pin_i[4] == pc_pin_i[2] && $stable(pa_pin_i[4])) [*5]
    |-> ptimer2_capture_in_o == pa_pin_i[4]) else $error("capture level");
endmodule : pemux_sva
bind pemux_top pemux_sva i_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_ack_o(wb_ack_o),
  .pa_pin_i(pa_pin_i), .pc_pin_i(pc_pin_i), .pa_out_o(pa_out_o), .pa_oe_n_o(pa_oe_n_o),
  .pe_oe_n_o(pe_oe_n_o), .analog_channel_7_o(analog_channel_7_o),
  .analog_channel_6_o(analog_channel_6_o), .analog_channel_5_o(analog_channel_5_o),
  .opamp_noninv_input_o(opamp_noninv_input_o), .io_supply_ref_o(io_supply_ref_o),
  .ptimer2_capture_in_o(ptimer2_capture_in_o), .sleep_i(sleep_i), .wake_o(wake_o));

// ---- testbench/pemux_pins.sv ----
// Far-side model: package pin levels of ports A to C
`timescale 1ns/10ps
module pemux_pins (
  // External levels, port C over B over A
  input wire logic [23:0] ext_i,
  // Port A drivers of the mux
  input wire logic [7:0] pa_out_i,
  input wire logic [7:0] pa_oe_n_i,
  // Resolved pins
  output logic [7:0] pa_pin_o,
  output logic [7:0] pb_pin_o,
  output logic [7:0] pc_pin_o
);
  // A driven pin shows the mux level, an input pin the outside level
  assign pa_pin_o = (pa_oe_n_i & ext_i[7:0]) | (~pa_oe_n_i & pa_out_i);
  assign pb_pin_o = ext_i[15:8];
  assign pc_pin_o = ext_i[23:16];
endmodule : pemux_pins

// ---- testbench/pemux_top_bench.sv ----
// Bench for the port E mux: registers, functions, routing, port bits and wake
`timescale 1ns/10ps
module pemux_top_bench;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, sleep = 1'h0, ack, wake;
  logic [7:0] adr = 8'h00, pa, pb, pc, pa_out, pa_oe_n, rte;
  logic [31:0] wdat = 32'h0, rdat;
  logic [23:0] ext = 24'h0;
  logic [4:0] pe_out, pe_oe_n;
  logic [6:0] ana;
  int num_errors = 0, comparisons = 0, wakes = 0;
  int ra[8] = '{4, 3, 19, 1, 4, 6, 5, 7};
  int rb[8] = '{18, 16, 7, 6, 20, 11, 10, 21};
  int rbit[8] = '{7, 6, 3, 0, 6, 5, 4, 0};
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake === 1'h1) wakes++;
  pemux_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pa_pin_i(pa), .pb_pin_i(pb), .pc_pin_i(pc), .pe_pin_i(5'h00), .pa_out_o(pa_out),
    .pa_oe_n_o(pa_oe_n), .pe_out_o(pe_out), .pe_oe_n_o(pe_oe_n), .analog_channel_7_o(ana[6]),
    .analog_channel_6_o(ana[5]), .analog_channel_5_o(ana[4]), .analog_channel_4_o(ana[3]),
    .opamp_noninv_input_o(ana[2]), .opamp_inv_input_o(ana[1]), .io_supply_ref_o(ana[0]),
    .ptimer2_capture_in_o(rte[7]), .ptimer1_capture_in_o(rte[6]),
    .ptimer2_ext_clock_o(rte[5]), .std_timer_ext_clock_o(rte[4]), .spi_a_select_o(rte[3]),
    .spi_a_data_in_o(rte[2]), .spi_a_clock_o(rte[1]), .shared_serial_rx_in_o(rte[0]),
    .sleep_i(sleep), .wake_o(wake));
  pemux_pins i_pins (.ext_i(ext), .pa_out_i(pa_out), .pa_oe_n_i(pa_oe_n), .pa_pin_o(pa),
    .pb_pin_o(pb), .pc_pin_o(pc));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'h1);
    chk("ack cycles", 32'h2, n);
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'h1, a, d, q);
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'h0, a, 8'h00, q);
    chk(nm, e, q);
  endtask : rc
  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("drive", 26'h3ffffff, {pa_out, pa_oe_n, pe_out, pe_oe_n});
    rc("sel low", pemux_pkg::ADDR_PE_SEL_LOW, 8'h00);
    rc("tmr route", pemux_pkg::ADDR_TMR_ROUTE, 8'h00);
    rc("ser route", pemux_pkg::ADDR_SER_ROUTE, 8'h00);
    rc("pa dir", pemux_pkg::ADDR_PA_DIR, 8'hff);
    rc("unmapped", 8'h40, 8'h00);
  endtask : t_reset
  task automatic t_func;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(pemux_pkg::ADDR_PE_SEL_LOW, {c, c, c, c});
      wr(pemux_pkg::ADDR_PE_SEL_HIGH, {6'h3f, c});
      repeat (2) @(posedge clk_i);
      chk("functions", {{4{c == 2'h1}}, {2{c == 2'h2}}, c == 2'h1}, ana);
      rc("sel high", pemux_pkg::ADDR_PE_SEL_HIGH, {6'h00, c});
    end
  endtask : t_func
  task automatic step(input logic [7:0] a, input logic [7:0] r, input int p, input int i,
    input logic e);
    ext <= 24'h1 << p;
    wr(a, r);
    repeat (5) @(posedge clk_i);
    chk("route", e, rte[7 - i]);
  endtask : step
  task automatic t_route;
    logic [7:0] a;
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? pemux_pkg::ADDR_TMR_ROUTE : pemux_pkg::ADDR_SER_ROUTE;
      step(a, 8'h00, ra[i], i, 1'h1);
      step(a, 8'h01 << rbit[i], ra[i], i, 1'h0);
      step(a, 8'h01 << rbit[i], rb[i], i, 1'h1);
      wr(a, 8'h00);
    end
  endtask : t_route
  task automatic t_rmw;
    logic [7:0] q;
    ext <= 24'h0000a0;
    wr(pemux_pkg::ADDR_PA_DIR, 8'hfe);
    repeat (4) @(posedge clk_i);
    chk("pa0 drive", 2'h2, {pa_out[0], pa_oe_n[0]});
    wb(1'h0, pemux_pkg::ADDR_PA_DATA, 8'h00, q);
    chk("pa read", 8'ha1, q);
    wr(pemux_pkg::ADDR_PA_DATA, q & 8'hfe);
    @(posedge clk_i);
    chk("pa latch", 8'ha0, pa_out);
    wr(pemux_pkg::ADDR_PA_DIR, 8'hff);
  endtask : t_rmw
  task automatic t_wake;
    wr(pemux_pkg::ADDR_PA_WAKE_EN, 8'h10);
    ext <= 24'h000030;
    sleep <= 1'h1;
    repeat (6) @(posedge clk_i);
    wakes = 0;
    ext <= 24'h000010;
    repeat (6) @(posedge clk_i);
    ext <= 24'h000000;
    repeat (6) @(posedge clk_i);
    chk("wakes asleep", 1, wakes);
    ext <= 24'h000010;
    sleep <= 1'h0;
    repeat (6) @(posedge clk_i);
    ext <= 24'h000000;
    repeat (6) @(posedge clk_i);
    chk("wakes awake", 1, wakes);
  endtask : t_wake
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_func();
    t_route();
    t_rmw();
    t_wake();
    finish_test();
  end
  initial begin
    #250000;
    num_errors++;
    finish_test();
  end
endmodule : pemux_top_bench
